/* ccpu_regs.vh */
// Purpose: register map, field positions and mode codes of the capture/compare/pwm pair
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   definitions only
`ifndef CCPU_REGS_VH
`define CCPU_REGS_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define CCPU_OFS_CTRL1     12'h000
`define CCPU_OFS_VAL1      12'h004
`define CCPU_OFS_CTRL2     12'h008
`define CCPU_OFS_VAL2      12'h00c
`define CCPU_OFS_STAT      12'h010
`define CCPU_OFS_MASK      12'h014
`define CCPU_OFS_TSEL      12'h018

// ---------------------------------------------------------------
// control fields and reset values
// ---------------------------------------------------------------
`define CCPU_MODE_MSB      3
`define CCPU_MODE_LSB      0
`define CCPU_DUTY_MSB      5
`define CCPU_DUTY_LSB      4
`define CCPU_CTRL_RST      6'h00
`define CCPU_VAL_RST       16'h0000

// ---------------------------------------------------------------
// mode codes
// ---------------------------------------------------------------
`define CCPU_M_OFF         4'h0
`define CCPU_M_TOGGLE      4'h2
`define CCPU_M_CAP_FALL    4'h4
`define CCPU_M_CAP_RISE    4'h5
`define CCPU_M_CAP_R4      4'h6
`define CCPU_M_CAP_R16     4'h7
`define CCPU_M_CMP_SET     4'h8
`define CCPU_M_CMP_CLR     4'h9
`define CCPU_M_CMP_IRQ     4'ha
`define CCPU_M_CMP_SPEV    4'hb

`endif

/* ccpu_unit.v */
// Purpose: one capture/compare/pwm unit, shared by the enhanced and the standard instance
// Assumes: pin input already synchronised, timers on sys_clk
// Notes:   enhanced pwm extras live elsewhere; this is the common core
`timescale 1ns/1ps
`include "ccpu_regs.vh"

module ccpu_unit (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire [3:0]  mode,
  input  wire [1:0]  duty_low_bits,
  input  wire [15:0] timer_val,
  input  wire [7:0]  period_timer,
  input  wire [1:0]  period_frac,
  input  wire        pin_sync,
  input  wire        val_wr,
  input  wire [15:0] val_wdata,
  output reg  [15:0] val_q,
  output reg         pin_out_q,
  output reg         pin_oe_q,
  output reg         event_q,
  output reg         spev_q
);

  // ---------------------------------------------------------------
  // edge detect and prescaler
  // ---------------------------------------------------------------
  reg        pin_prev_q;
  reg  [3:0] presc_q;
  reg  [3:0] mode_prev_q;
  wire       rise     = pin_sync & ~pin_prev_q;
  wire       fall     = ~pin_sync & pin_prev_q;
  wire       is_cap   = (mode[3:2] == 2'b01);
  wire       is_cmp   = (mode[3:2] == 2'b10) || (mode == `CCPU_M_TOGGLE);
  wire       is_pwm   = (mode[3:2] == 2'b11);
  wire       entered  = (mode != mode_prev_q);
  wire       match    = (timer_val == val_q);
  wire [9:0] duty     = {val_q[7:0], duty_low_bits};
  reg        cap_ev;

  always @* begin
    case (mode)
      `CCPU_M_CAP_FALL: cap_ev = fall;
      `CCPU_M_CAP_RISE: cap_ev = rise;
      `CCPU_M_CAP_R4:   cap_ev = rise && (presc_q[1:0] == 2'h3); // RQ6
      `CCPU_M_CAP_R16:  cap_ev = rise && (presc_q == 4'hf);     // RQ7
      default:          cap_ev = 1'b0;
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_q  <= 1'b0;
      presc_q     <= 4'h0;
      mode_prev_q <= 4'h0;
      val_q       <= `CCPU_VAL_RST;
      pin_out_q   <= 1'b0;
      pin_oe_q    <= 1'b0;
      event_q     <= 1'b0;
      spev_q      <= 1'b0;
    end else begin
      pin_prev_q  <= pin_sync;
      mode_prev_q <= mode;
      event_q     <= 1'b0;
      spev_q      <= 1'b0;
      if (!is_cap)
        presc_q <= 4'h0; // RQ13
      else if (rise)
        presc_q <= presc_q + 4'h1;
      // later captures overwrite unread ones
      if (val_wr)
        val_q <= val_wdata;
      else if (is_cap && cap_ev) begin
        val_q   <= timer_val; // RQ2 RQ12 RQ14
        event_q <= 1'b1;      // RQ12
      end
      // RQ5 RQ10: 0000 idles the unit, 0001/0011 do nothing
      if (mode == `CCPU_M_OFF) begin
        pin_out_q <= 1'b0;
        pin_oe_q  <= 1'b0;
      end else if (is_cmp) begin
        pin_oe_q <= (mode != `CCPU_M_CMP_IRQ) && (mode != `CCPU_M_CMP_SPEV);
        if (entered && mode == `CCPU_M_CMP_SET)
          pin_out_q <= 1'b0; // RQ8
        else if (entered && mode == `CCPU_M_CMP_CLR)
          pin_out_q <= 1'b1; // RQ8
        else if (match && !entered) begin
          event_q <= 1'b1; // RQ8
          case (mode)
            `CCPU_M_TOGGLE:   pin_out_q <= ~pin_out_q;
            `CCPU_M_CMP_SET:  pin_out_q <= 1'b1; // RQ8
            `CCPU_M_CMP_CLR:  pin_out_q <= 1'b0; // RQ8
            `CCPU_M_CMP_SPEV: spev_q    <= 1'b1; // RQ11
            default:          pin_out_q <= pin_out_q;
          endcase
        end
      end else if (is_pwm) begin
        // RQ9 RQ11 RQ14: 10-bit duty against the 8-bit period timer plus fraction
        pin_oe_q  <= 1'b1;
        pin_out_q <= ({period_timer, period_frac} < duty);
      end else
        pin_oe_q <= 1'b0;
    end
  end

endmodule // ccpu_unit

/* ccpu_top.v */
// Purpose: apb-attached pair of capture/compare/pwm units
// Assumes: timers and period counter come from elsewhere on sys_clk
// Notes:   pin inputs pass two flops; enhanced pwm extras are outside
//
// Behaviour
// [RQ1] two independent units, each with its own control register
// [RQ2] each unit has one 16-bit value register for capture, compare or duty
// [RQ3] first unit is the enhanced variant with standard capture and compare
// [RQ4] second unit is standard: capture, compare and basic pwm only
// [RQ5] capture and compare logic is one shared implementation
// [RQ6] mode 0110 captures every fourth rising edge via prescaler
// [RQ7] mode 0111 captures every sixteenth rising edge
// [RQ8] 1000 low then high on match, 1001 reverse; both set event flag
// [RQ9] control bits 5:4 are duty low bits; value low byte holds upper eight
// [RQ10] mode 0000 disables and resets unit; 0001 and 0011 do nothing
// [RQ11] modes 11xx are pwm; 1011 match raises special event trigger
// [RQ12] capture sets event flag cleared by software; new capture overwrites
// [RQ13] prescaler clears when unit off or not capturing, and on reset
// [RQ14] capture/compare use a selected 16-bit timer; pwm uses 8-bit period timer
`timescale 1ns/1ps
`include "ccpu_regs.vh"

module ccpu_top (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [15:0] timebase_one,
  input  wire [15:0] timebase_three,
  input  wire [7:0]  period_timer,
  input  wire [1:0]  period_frac,
  input  wire        enh_pin_in,
  input  wire        std_pin_in,
  output reg         enh_pin_out,
  output reg         enh_pin_oe,
  output reg         std_pin_out,
  output reg         std_pin_oe,
  output reg         timer_reset_q,
  output reg         adc_start_q,
  output reg         irq_q
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [5:0]  ctrl_q [0:1];
  reg  [1:0]  stat_q;
  reg  [1:0]  mask_q;
  reg  [1:0]  tsel_q;
  reg  [1:0]  sync1_q;
  reg  [1:0]  sync2_q;
  wire [15:0] val    [0:1];
  wire [1:0]  pout;
  wire [1:0]  poe;
  wire [1:0]  ev;
  wire [1:0]  spev;
  wire [1:0]  pin_raw = {std_pin_in, enh_pin_in};
  wire        acc    = psel && penable && pready;
  wire        wr     = acc && pwrite;
  wire        known  = (paddr <= `CCPU_OFS_TSEL) && (paddr[1:0] == 2'b00);

  // ---------------------------------------------------------------
  // units: index 0 enhanced, index 1 standard
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_unit
      wire [11:0] vofs = g ? `CCPU_OFS_VAL2 : `CCPU_OFS_VAL1;
      ccpu_unit u_unit ( // RQ1 RQ3 RQ4 RQ5
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .mode         (ctrl_q[g][`CCPU_MODE_MSB:`CCPU_MODE_LSB]),
        .duty_low_bits(ctrl_q[g][`CCPU_DUTY_MSB:`CCPU_DUTY_LSB]),
        .timer_val    (tsel_q[g] ? timebase_three : timebase_one), // RQ14
        .period_timer (period_timer),
        .period_frac  (period_frac),
        .pin_sync     (sync2_q[g]),
        .val_wr       (wr && paddr == vofs),
        .val_wdata    (pwdata[15:0]),
        .val_q        (val[g]),
        .pin_out_q    (pout[g]),
        .pin_oe_q     (poe[g]),
        .event_q      (ev[g]),
        .spev_q       (spev[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // bus slave, status and interrupt
  // ---------------------------------------------------------------
  // no wait state; read data is registered during the setup cycle
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q[0]     <= `CCPU_CTRL_RST;
      ctrl_q[1]     <= `CCPU_CTRL_RST;
      stat_q        <= 2'h0;
      mask_q        <= 2'h0;
      tsel_q        <= 2'h0;
      sync1_q       <= 2'h0;
      sync2_q       <= 2'h0;
      prdata        <= 32'h0000_0000;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      enh_pin_out   <= 1'b0;
      enh_pin_oe    <= 1'b0;
      std_pin_out   <= 1'b0;
      std_pin_oe    <= 1'b0;
      timer_reset_q <= 1'b0;
      adc_start_q   <= 1'b0;
      irq_q         <= 1'b0;
    end else begin
      sync1_q       <= pin_raw;
      sync2_q       <= sync1_q;
      enh_pin_out   <= pout[0];
      enh_pin_oe    <= poe[0];
      std_pin_out   <= pout[1];
      std_pin_oe    <= poe[1];
      timer_reset_q <= |spev; // RQ11
      adc_start_q   <= spev[1]; // RQ11
      pready        <= psel && !penable;
      pslverr       <= psel && !penable && !known;
      if (psel && !penable) begin
        case (paddr)
          `CCPU_OFS_CTRL1: prdata <= {26'h0, ctrl_q[0]};
          `CCPU_OFS_VAL1:  prdata <= {16'h0, val[0]};
          `CCPU_OFS_CTRL2: prdata <= {26'h0, ctrl_q[1]};
          `CCPU_OFS_VAL2:  prdata <= {16'h0, val[1]};
          `CCPU_OFS_STAT:  prdata <= {30'h0, stat_q};
          `CCPU_OFS_MASK:  prdata <= {30'h0, mask_q};
          `CCPU_OFS_TSEL:  prdata <= {30'h0, tsel_q};
          default:         prdata <= 32'h0000_0000;
        endcase
      end
      if (wr && paddr == `CCPU_OFS_CTRL1) ctrl_q[0] <= pwdata[5:0]; // RQ1 RQ9
      if (wr && paddr == `CCPU_OFS_CTRL2) ctrl_q[1] <= pwdata[5:0]; // RQ1 RQ9
      if (wr && paddr == `CCPU_OFS_MASK)  mask_q    <= pwdata[1:0];
      if (wr && paddr == `CCPU_OFS_TSEL)  tsel_q    <= pwdata[1:0];
      // set wins over a same-cycle write-one clear
      stat_q <= (stat_q & ~((wr && paddr == `CCPU_OFS_STAT) ? pwdata[1:0] : 2'h0)) | ev; // RQ12
      irq_q  <= |(stat_q & mask_q);
    end
  end

endmodule // ccpu_top

/* ccpu_far.sv */
// Purpose: far side model: timer counts and pwm period count
// Assumes: run low parks the counts at fixed values
// Notes:   special event clears the count, so a match repeats later
`timescale 1ns/1ps
module ccpu_far (
  input  wire        sys_clk,
  input  wire        run,
  input  wire        trst,
  output reg  [15:0] t1,
  output wire [15:0] t3,
  output wire [9:0]  per
);
  assign t3  = ~t1;
  assign per = t1[9:0];
  always @(posedge sys_clk) begin
    if (!run)
      t1 <= 16'h0123;
    else if (trst)
      t1 <= 16'h0000;
    else
      t1 <= t1 + 16'h0001;
  end
endmodule // ccpu_far

/* ccpu_top_monitor.sv */
// Purpose: port checker for ccpu_top
// Assumes: one clock domain
// Notes:   bound at the foot of this file
`timescale 1ns/1ps
module ccpu_top_monitor (
  input wire        sys_clk,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        timer_reset_q,
  input wire        adc_start_q,
  input wire        irq_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready held");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("ready outside access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_ref; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_ref: assert property (p_ref) else $error("refused read not zero");
  property p_adc; adc_start_q |-> timer_reset_q; endproperty
  a_adc: assert property (p_adc) else $error("conversion without trigger");
  property p_trp; timer_reset_q |=> !timer_reset_q; endproperty
  a_trp: assert property (p_trp) else $error("trigger too long");
  property p_rst; $rose(rst_n) |-> !irq_q && !pready; endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear");
  // only software clears a flag, so irq can only fall after a write
  property p_irq;
    $fell(irq_q) |-> $past(pwrite && penable, 2) || $past(pwrite && penable, 3);
  endproperty
  a_irq: assert property (p_irq) else $error("irq fell untouched");
  c_adc: cover property (adc_start_q);
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq_q));
endmodule // ccpu_top_monitor
bind ccpu_top ccpu_top_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timer_reset_q(timer_reset_q), .adc_start_q(adc_start_q),
  .irq_q(irq_q));

/* tb.sv */
// Purpose: self-checking bench for ccpu_top
// Assumes: far model parks timer one at 0123 and timer three at fedc while run is low
// Notes:   expectations follow from the parked timer values
`timescale 1ns/1ps
`include "ccpu_regs.vh"
module tb;
  reg         sys_clk, rst_n, psel, penable, pwrite, run, e_in, s_in;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  reg         er;
  wire [31:0] prdata;
  wire [15:0] t1, t3;
  wire [9:0]  per;
  wire        pready, pslverr, eo, eoe, so, soe, trst, adc, irq;
  integer     err_total, n_tests;
  ccpu_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timebase_one(t1), .timebase_three(t3), .period_timer(per[9:2]),
    .period_frac(per[1:0]), .enh_pin_in(e_in), .std_pin_in(s_in), .enh_pin_out(eo),
    .enh_pin_oe(eoe), .std_pin_out(so), .std_pin_oe(soe), .timer_reset_q(trst),
    .adc_start_q(adc), .irq_q(irq));
  ccpu_far far (.sys_clk(sys_clk), .run(run), .trst(trst), .t1(t1), .t3(t3), .per(per));
  task ck(input [31:0] s, input [31:0] e, input string nm);
    n_tests = n_tests + 1;
    if (s !== e) begin
      err_total = err_total + 1;
      $display("BAD %0s exp %h got %h", nm, e, s);
    end
  endtask
  task xf(input w, input [11:0] a, input [31:0] d);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
    @(posedge sys_clk);
    penable <= 1'h1;
    @(posedge sys_clk);
    while (!pready) @(posedge sys_clk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task pl(input u, input [7:0] n);
    repeat (n) begin
      @(posedge sys_clk);
      if (u) s_in <= 1'h1; else e_in <= 1'h1;
      repeat (3) @(posedge sys_clk);
      {e_in, s_in} <= 2'h0;
      repeat (3) @(posedge sys_clk);
    end
    repeat (6) @(posedge sys_clk);
  endtask
  task t_regs;
    xf(1, 12'h002, 32'h3f); ck(er, 1, "unaligned");
    xf(0, `CCPU_OFS_CTRL1, 0); ck(rd, 0, "ctrl1"); ck(er, 0, "okay");
    xf(1, `CCPU_OFS_CTRL2, 32'hff); xf(0, `CCPU_OFS_CTRL2, 0); ck(rd, 32'h3f, "ctrl2");
    xf(1, `CCPU_OFS_VAL2, 32'h1abcd); xf(0, `CCPU_OFS_VAL2, 0); ck(rd, 32'habcd, "val2");
    xf(1, `CCPU_OFS_CTRL2, 0);
    xf(0, 12'h01c, 0); ck(rd, 0, "unmapped"); ck(er, 1, "slverr");
    for (int m = 1; m < 4; m = m + 2) begin
      xf(1, `CCPU_OFS_CTRL2, m); pl(1, 2); ck({irq, soe}, 0, "reserved");
    end
    $display("regs done");
  endtask
  task t_cap;
    xf(1, `CCPU_OFS_MASK, 32'h3);
    xf(1, `CCPU_OFS_CTRL1, `CCPU_M_CAP_R4); pl(0, 2);
    xf(1, `CCPU_OFS_CTRL1, `CCPU_M_OFF); // prescaler must restart from zero
    xf(1, `CCPU_OFS_CTRL1, `CCPU_M_CAP_R4); pl(0, 3); ck(irq, 0, "early");
    pl(0, 1); ck(irq, 1, "irq");
    xf(0, `CCPU_OFS_VAL1, 0); ck(rd, 32'h0123, "cap4");
    xf(1, `CCPU_OFS_TSEL, 1); pl(0, 4);
    xf(0, `CCPU_OFS_VAL1, 0); ck(rd, 32'hfedc, "overwrite");
    // a switch between prescalers keeps the count, so pass through off first
    xf(1, `CCPU_OFS_STAT, 1); xf(1, `CCPU_OFS_CTRL1, `CCPU_M_OFF);
    xf(1, `CCPU_OFS_CTRL1, `CCPU_M_CAP_R16); pl(0, 15);
    xf(0, `CCPU_OFS_STAT, 0); ck(rd, 0, "cap15");
    pl(0, 1); xf(0, `CCPU_OFS_STAT, 0); ck(rd, 1, "cap16");
    xf(1, `CCPU_OFS_STAT, 1); xf(1, `CCPU_OFS_CTRL1, 0); xf(1, `CCPU_OFS_TSEL, 0);
    $display("capture done");
  endtask
  task t_cmp;
    xf(1, `CCPU_OFS_VAL2, 32'h130);
    for (int m = 8; m < 10; m = m + 1) begin
      run <= 0; xf(1, `CCPU_OFS_CTRL2, m); repeat (4) @(posedge sys_clk);
      ck({soe, so}, m == 9 ? 3 : 2, "entry");
      run <= 1; repeat (40) @(posedge sys_clk);
      ck({soe, so}, m == 9 ? 2 : 3, "match");
      xf(0, `CCPU_OFS_STAT, 0); ck(rd, 2, "flag"); xf(1, `CCPU_OFS_STAT, 2);
    end
    xf(1, `CCPU_OFS_CTRL2, `CCPU_M_OFF);
    $display("compare done");
  endtask
  task t_more;
    run <= 0; xf(1, `CCPU_OFS_CTRL2, `CCPU_M_CAP_FALL);
    s_in <= 1'h1; repeat (6) @(posedge sys_clk);
    xf(0, `CCPU_OFS_STAT, 0); ck(rd, 0, "no fall");
    s_in <= 1'h0; repeat (6) @(posedge sys_clk);
    xf(0, `CCPU_OFS_STAT, 0); ck(rd, 2, "fall");
    xf(1, `CCPU_OFS_STAT, 2); xf(1, `CCPU_OFS_CTRL2, `CCPU_M_CAP_RISE); pl(1, 1);
    xf(0, `CCPU_OFS_STAT, 0); ck(rd, 2, "rise");
    xf(0, `CCPU_OFS_VAL2, 0); ck(rd, 32'h0123, "rise val");
    xf(1, `CCPU_OFS_CTRL2, `CCPU_M_OFF); xf(1, `CCPU_OFS_STAT, 2);
    xf(1, `CCPU_OFS_VAL1, 32'h130); xf(1, `CCPU_OFS_VAL2, 32'h130);
    xf(1, `CCPU_OFS_CTRL1, `CCPU_M_TOGGLE); xf(1, `CCPU_OFS_CTRL2, `CCPU_M_CMP_IRQ);
    run <= 1; repeat (40) @(posedge sys_clk);
    ck({eoe, eo, soe}, 3'h6, "cmp pins"); ck(irq, 1, "irq set");
    xf(1, `CCPU_OFS_STAT, 1); xf(0, `CCPU_OFS_STAT, 0); ck(rd, 2, "w1c");
    xf(1, `CCPU_OFS_MASK, 1); repeat (2) @(posedge sys_clk); ck(irq, 0, "masked");
    xf(1, `CCPU_OFS_CTRL1, 0); xf(1, `CCPU_OFS_CTRL2, 0); xf(1, `CCPU_OFS_STAT, 3);
    $display("more modes done");
  endtask
  task t_spev;
    integer t, a;
    for (int u = 0; u < 2; u = u + 1) begin
      run <= 0; t = 0; a = 0;
      xf(1, u ? `CCPU_OFS_VAL2 : `CCPU_OFS_VAL1, 32'h130);
      xf(1, u ? `CCPU_OFS_CTRL2 : `CCPU_OFS_CTRL1, `CCPU_M_CMP_SPEV); run <= 1;
      repeat (40) begin @(posedge sys_clk); t = t | trst; a = a | adc; end
      ck(t, 1, "trig"); ck(a, u, "adc"); ck({eoe, soe}, 0, "oe");
      xf(1, u ? `CCPU_OFS_CTRL2 : `CCPU_OFS_CTRL1, 0); xf(1, `CCPU_OFS_STAT, 3);
    end
    $display("special event done");
  endtask
  task t_pwm;
    run <= 0; xf(1, `CCPU_OFS_VAL1, 32'h49); xf(1, `CCPU_OFS_CTRL1, 32'h0c);
    repeat (4) @(posedge sys_clk); ck({eoe, eo}, 3, "duty above");
    xf(1, `CCPU_OFS_VAL1, 32'h48); xf(1, `CCPU_OFS_CTRL1, 32'h3c);
    repeat (4) @(posedge sys_clk); ck(eo, 0, "duty equal");
    $display("pwm done");
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, run, e_in, s_in} = 0;
    err_total = 0;
    n_tests = 0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1;
    t_regs; t_cap; t_cmp; t_spev; t_more; t_pwm;
    summarize;
  end
  initial begin
    #400000;
    err_total = err_total + 1;
    summarize;
  end
endmodule // tb
